// ### scanline_brightness_cmds_bench.sv
`timescale 1ns/1ps
module scanline_brightness_cmds_bench;
    import slb_pkg::*;
    logic mclk = 0, rst_n = 0, sw_reset = 0, sleep = 0, serial = 0;
    logic cds, wr_n, rd_n, oe_n;
    logic [BUS_W-1:0] hdata, odata, d;
    logic [BYTE_W-1:0] brt;
    int num_errors = 0, comparisons = 0, cyc = 0, n, e, v;
    always #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= (!rst_n || sw_reset) ? 0 : cyc + 1;
    slb_cmd_top #(.VERTICAL_ACTIVE_LINES_LINES(8), .CLKS_PER_LINE(4)) uut (.I_MCLK(mclk), .I_RST_N(rst_n),
        .I_SW_RESET(sw_reset), .I_SLEEP(sleep), .I_SERIAL_MODE(serial),
        .I_COMMAND_DATA_SELECT(cds), .I_WRITE_STROBE_N(wr_n), .I_READ_STROBE_N(rd_n),
        .I_DATA(hdata), .O_DATA(odata), .O_DATA_OE_N(oe_n), .O_BRIGHTNESS_VALUE(brt));
    slb_host_model host (.i_clk(mclk), .i_data(odata), .i_data_oe_n(oe_n), .o_cds(cds),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_data(hdata));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [BUS_W-1:0] exp);
        host.read_byte(d);
        check(d, exp);
    endtask
    task automatic set_brt(input logic [7:0] b);
        host.write_byte(1'b0, CMD_WR_BRT);
        host.write_byte(1'b1, b);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        check({10'h000, brt}, 18'h00000);
        check({17'h00000, oe_n}, 18'h00001);
        $display("reset test done");
        set_brt(8'hAB);
        host.write_byte(1'b1, 8'h12);
        check({10'h000, brt}, 18'h000AB);
        host.write_byte(1'b0, CMD_RD_BRT);
        rd(18'h00000);
        rd(18'h000AB);
        for (int i = 0; i < 2; i++) rd(18'h000AB);
        $display("brightness write and read test done");
        for (int i = 0; i < 2; i++) begin
            set_brt(i ? BRT_MAX : BRT_MIN);
            check({10'h000, brt}, i ? 18'h000FF : 18'h00000);
        end
        serial = 1'b1;
        host.write_byte(1'b0, CMD_RD_BRT);
        for (int i = 0; i < 2; i++) rd(18'h000FF);
        serial = 1'b0;
        $display("limits and serial read test done");
        // snapshot takes the line of edge n+9: one hold, the select lead of four, then the four-edge pin delay
        host.write_byte(1'b0, CMD_GET_SCAN);
        n = cyc;
        rd(18'h00000);
        host.read_byte(d);
        check(d & 18'h3FFFC, 18'h00000);
        v = d[1:0] * 256;
        host.read_byte(d);
        v = v + d[7:0];
        e = ((n + 9) / 4) % 20;
        check(18'(v), 18'(e));
        $display("scan line test done");
        @(posedge mclk);
        #1 sw_reset = 1'b1;
        sleep = 1'b1;
        @(posedge mclk);
        #1 sw_reset = 1'b0;
        check({10'h000, brt}, 18'h00000);
        host.write_byte(1'b0, CMD_GET_SCAN);
        for (int i = 0; i < 3; i++) rd(18'h00000);
        sleep = 1'b0;
        $display("software reset test done");
        give_verdict;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict;
    end
endmodule // scanline_brightness_cmds_bench

// ### slb_cmd_properties.sv
`timescale 1ns/1ps
module slb_cmd_properties import slb_pkg::*; (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_SW_RESET,
    input wire logic I_COMMAND_DATA_SELECT,
    input wire logic I_WRITE_STROBE_N,
    input wire logic I_READ_STROBE_N,
    input wire logic [BUS_W-1:0] O_DATA,
    input wire logic O_DATA_OE_N,
    input wire logic [BYTE_W-1:0] O_BRIGHTNESS_VALUE
);
    // ------------------------------------------------
    // cycles since the write strobe was last low
    // ------------------------------------------------
    logic [3:0] wr_age_reg, wr_age_next;
    always_comb begin
        wr_age_next = (wr_age_reg == 4'hF) ? wr_age_reg : wr_age_reg + 4'h1;
        if (!I_RST_N || !I_WRITE_STROBE_N) wr_age_next = I_RST_N ? 4'h0 : 4'hF;
    end
    always_ff @(posedge I_MCLK) begin
        wr_age_reg <= wr_age_next;
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    chk_upper_lines_zero: assert property (O_DATA[17:8] == 10'h000)
        else $error("upper read lines not zero");
    chk_reset_values: assert property (disable iff (1'b0) !I_RST_N |=>
        O_BRIGHTNESS_VALUE == 8'h00 && O_DATA_OE_N && O_DATA == 18'h00000)
        else $error("reset values wrong");
    chk_sw_reset_brt: assert property (I_SW_RESET |=> O_BRIGHTNESS_VALUE == 8'h00)
        else $error("brightness kept over software reset");
    // a slack window: the synchroniser depth fixes the delay only to a cycle or two
    chk_brt_change_cause: assert property ($changed(O_BRIGHTNESS_VALUE)
        && !$past(I_SW_RESET) |-> wr_age_reg inside {[4'h3:4'h8]})
        else $error("brightness changed without a write");
    chk_answer_cause: assert property ($fell(O_DATA_OE_N) |->
        !$past(I_READ_STROBE_N, 4) && I_COMMAND_DATA_SELECT)
        else $error("read answer without a read strobe");
    chk_read_data_holds: assert property (!O_DATA_OE_N && !I_READ_STROBE_N
        && I_COMMAND_DATA_SELECT |=> !O_DATA_OE_N && $stable(O_DATA))
        else $error("read data dropped during the strobe");
    chk_read_release: assert property ($rose(I_READ_STROBE_N) |-> ##[1:7] O_DATA_OE_N)
        else $error("read data not released");
    chk_release_cause: assert property ($rose(O_DATA_OE_N) |->
        $past(I_READ_STROBE_N, 4) || !$past(I_COMMAND_DATA_SELECT, 4))
        else $error("read data released too early");
    cover property ($fell(O_DATA_OE_N));
    cover property ($changed(O_BRIGHTNESS_VALUE));
    cover property (I_SW_RESET);
endmodule // slb_cmd_properties

bind slb_cmd_top slb_cmd_properties chk (.I_MCLK, .I_RST_N, .I_SW_RESET,
    .I_COMMAND_DATA_SELECT, .I_WRITE_STROBE_N, .I_READ_STROBE_N, .O_DATA,
    .O_DATA_OE_N, .O_BRIGHTNESS_VALUE);

// ### slb_cmd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Command bytes come with select low and parameters with select high, writes are taken on the write strobe rising edge and read data is driven for each
//   read strobe cycle made while select is high.
// - Command 45h answers a dummy read, then the scan line bits 9:8 in the low two bits, then bits 7:0.
// - The scan line counter runs over sync, back porch, active and front porch lines and is zero on the first sync line.
// - In sleep the returned scan line has no defined meaning.
// - The scan line is zero after power-on, hardware reset and software reset.
// - Command 51h takes one parameter byte as the new brightness value.
// - Brightness 00h is the lowest and FFh the highest level.
// - Command 52h answers a dummy byte and then the stored brightness.
// - On the parallel bus any read after the second keeps returning the brightness.
// - On the serial link the brightness read sends only the brightness, with no dummy byte.
// - Brightness resets to 00h on power-on, hardware reset and software reset.
module slb_cmd_top import slb_pkg::*; #(
    parameter int VSYNC_LINES = 4,
    parameter int VBP_LINES = 4,
    parameter int VERTICAL_ACTIVE_LINES_LINES = 320,
    parameter int VFP_LINES = 4,
    parameter int CLKS_PER_LINE = 64
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_SW_RESET,
    input wire logic I_SLEEP,
    input wire logic I_SERIAL_MODE,
    input wire logic I_COMMAND_DATA_SELECT,
    input wire logic I_WRITE_STROBE_N,
    input wire logic I_READ_STROBE_N,
    input wire logic [BUS_W-1:0] I_DATA,
    output logic [BUS_W-1:0] O_DATA,
    output logic O_DATA_OE_N,
    output logic [BYTE_W-1:0] O_BRIGHTNESS_VALUE
);

    localparam int PIN_W = BUS_W + 3;
    localparam int IDX_CDS = BUS_W;
    localparam int IDX_WR = BUS_W + 1;
    localparam int IDX_RD = BUS_W + 2;
    localparam logic [PIN_W-1:0] PIN_IDLE = {3'b111, 18'h00000};
    localparam logic [1:0] IDX_LAST = 2'h2;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] s1_reg;
    logic [PIN_W-1:0] s2_reg;
    logic [PIN_W-1:0] s3_reg;
    logic [PIN_W-1:0] filt_reg;
    logic [PIN_W-1:0] filt_next;

    assign pins_raw = {I_READ_STROBE_N, I_WRITE_STROBE_N, I_COMMAND_DATA_SELECT, I_DATA};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            // a change is accepted only once stages two and three agree
            always_comb begin
                filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
            end

            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    s1_reg[gi] <= PIN_IDLE[gi];
                    s2_reg[gi] <= PIN_IDLE[gi];
                    s3_reg[gi] <= PIN_IDLE[gi];
                    filt_reg[gi] <= PIN_IDLE[gi];
                end else begin
                    s1_reg[gi] <= pins_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    filt_reg[gi] <= filt_next[gi];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // strobe edges
    // ---------------------------------------------------------------
    logic wr_n_prev_reg;
    logic rd_n_prev_reg;
    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic cds;
    logic [BYTE_W-1:0] low_byte;

    always_comb begin
        wr_rise = filt_reg[IDX_WR] && !wr_n_prev_reg;
        rd_fall = !filt_reg[IDX_RD] && rd_n_prev_reg;
        rd_rise = filt_reg[IDX_RD] && !rd_n_prev_reg;
        cds = filt_reg[IDX_CDS];
        // upper lines never reach the decoder
        low_byte = filt_reg[BYTE_W-1:0];
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            wr_n_prev_reg <= 1'b1;
            rd_n_prev_reg <= 1'b1;
        end else begin
            wr_n_prev_reg <= filt_reg[IDX_WR];
            rd_n_prev_reg <= filt_reg[IDX_RD];
        end
    end

    // ---------------------------------------------------------------
    // scan line timer
    // ---------------------------------------------------------------
    slb_line_if lif();

    assign lif.clear = I_SW_RESET;
    assign lif.sleep = I_SLEEP;

    slb_line_timer #(
        .VSYNC_LINES(VSYNC_LINES),
        .VBP_LINES(VBP_LINES),
        .VERTICAL_ACTIVE_LINES_LINES(VERTICAL_ACTIVE_LINES_LINES),
        .VFP_LINES(VFP_LINES),
        .CLKS_PER_LINE(CLKS_PER_LINE)
    ) u_timer (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .lif(lif)
    );

    // ---------------------------------------------------------------
    // command tracking and brightness store
    // ---------------------------------------------------------------
    slb_cmd_t cmd_reg;
    slb_cmd_t cmd_next;
    logic brt_taken_reg;
    logic brt_taken_next;
    logic [BYTE_W-1:0] brt_reg;
    logic [BYTE_W-1:0] brt_next;

    always_comb begin
        cmd_next = cmd_reg;
        brt_taken_next = brt_taken_reg;
        brt_next = brt_reg;
        if (wr_rise) begin
            if (!cds) begin
                // a command byte always restarts the sequence
                brt_taken_next = 1'b0;
                unique case (low_byte)
                    CMD_GET_SCAN: cmd_next = SLB_SCAN;
                    CMD_WR_BRT: cmd_next = SLB_BWR;
                    CMD_RD_BRT: cmd_next = SLB_BRD;
                    default: cmd_next = SLB_IDLE;
                endcase
            end else if (cmd_reg == SLB_BWR && !brt_taken_reg) begin
                // only the first parameter loads; extras are dropped
                brt_next = low_byte;
                brt_taken_next = 1'b1;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || I_SW_RESET) begin
            cmd_reg <= SLB_IDLE;
            brt_taken_reg <= 1'b0;
            brt_reg <= BRT_RESET;
        end else begin
            cmd_reg <= cmd_next;
            brt_taken_reg <= brt_taken_next;
            brt_reg <= brt_next;
        end
    end

    // ---------------------------------------------------------------
    // read sequencing
    // ---------------------------------------------------------------
    logic [1:0] idx_reg;
    logic [1:0] idx_next;
    logic [SCAN_W-1:0] snap_reg;
    logic [SCAN_W-1:0] snap_next;
    logic [BYTE_W-1:0] rd_byte;

    // byte for the current read slot
    always_comb begin
        rd_byte = DUMMY_BYTE;
        unique case (cmd_reg)
            SLB_SCAN: begin
                if (idx_reg == 2'h1) begin
                    rd_byte = {6'h00, snap_reg[SCAN_HI_LSB +: SCAN_HI_W]};
                end else if (idx_reg == IDX_LAST) begin
                    rd_byte = snap_reg[BYTE_W-1:0];
                end else begin
                    rd_byte = DUMMY_BYTE;
                end
            end
            SLB_BRD: begin
                if (I_SERIAL_MODE) begin
                    rd_byte = brt_reg;
                end else if (idx_reg == 2'h0) begin
                    rd_byte = DUMMY_BYTE;
                end else begin
                    // third and later reads repeat the value
                    rd_byte = brt_reg;
                end
            end
            SLB_IDLE, SLB_BWR: rd_byte = DUMMY_BYTE;
        endcase
    end

    always_comb begin
        idx_next = idx_reg;
        snap_next = snap_reg;
        if (wr_rise && !cds) begin
            idx_next = 2'h0;
        end else if (rd_rise && cds && idx_reg != IDX_LAST) begin
            // saturates so later reads stay on the last slot
            idx_next = idx_reg + 2'h1;
        end
        if (rd_fall && cds && cmd_reg == SLB_SCAN && idx_reg == 2'h0) begin
            // snapshot at the dummy read keeps both bytes coherent
            snap_next = lif.line;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || I_SW_RESET) begin
            idx_reg <= 2'h0;
            snap_reg <= SCAN_RESET;
        end else begin
            idx_reg <= idx_next;
            snap_reg <= snap_next;
        end
    end

    // ---------------------------------------------------------------
    // data bus drive
    // ---------------------------------------------------------------
    logic [BUS_W-1:0] dout_reg;
    logic [BUS_W-1:0] dout_next;
    logic oe_n_reg;
    logic oe_n_next;

    always_comb begin
        dout_next = dout_reg;
        oe_n_next = oe_n_reg;
        if (rd_fall && cds) begin
            // upper lines driven low, only the low byte carries data
            dout_next = {10'h000, rd_byte};
            oe_n_next = 1'b0;
        end else if (rd_rise || !cds) begin
            oe_n_next = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            dout_reg <= 18'h00000;
            oe_n_reg <= 1'b1;
        end else begin
            dout_reg <= dout_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign O_DATA = dout_reg;
    assign O_DATA_OE_N = oe_n_reg;
    assign O_BRIGHTNESS_VALUE = brt_reg;

endmodule // slb_cmd_top

// ### slb_host_model.sv
`timescale 1ns/1ps
module slb_host_model import slb_pkg::*; (
    input wire logic i_clk,
    input wire logic [BUS_W-1:0] i_data,
    input wire logic i_data_oe_n,
    output logic o_cds,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic [BUS_W-1:0] o_data
);
    initial begin
        o_cds = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_data = 18'h00000;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // junk on the upper lines, then flipped once the write is over
    task automatic write_byte(input logic cds, input logic [7:0] b);
        hold(1);
        o_cds = cds;
        o_data = {10'h3FF, b};
        o_wr_n = 1'b0;
        hold(8);
        o_wr_n = 1'b1;
        hold(8);
        o_data = ~o_data;
        if (!cds && b == CMD_GET_SCAN) hold(HOST_WAIT_CYC);
    endtask
    task automatic read_byte(output logic [BUS_W-1:0] d);
        hold(1);
        // select settles before the strobe so skew cannot drop the read
        o_cds = 1'b1;
        hold(4);
        o_rd_n = 1'b0;
        hold(7);
        d = (i_data_oe_n === 1'b0) ? i_data : 'x;
        o_rd_n = 1'b1;
        hold(8);
    endtask
endmodule // slb_host_model

// ### slb_line_if.sv
`timescale 1ns/1ps
interface slb_line_if import slb_pkg::*; ();
    logic [SCAN_W-1:0] line;
    logic clear;
    logic sleep;

    modport timer(output line, input clear, input sleep);
    modport user(input line, output clear, output sleep);
endinterface

// ### slb_line_timer.sv
`timescale 1ns/1ps
module slb_line_timer import slb_pkg::*; #(
    parameter int VSYNC_LINES = 4,
    parameter int VBP_LINES = 4,
    parameter int VERTICAL_ACTIVE_LINES_LINES = 320,
    parameter int VFP_LINES = 4,
    parameter int CLKS_PER_LINE = 64
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    slb_line_if.timer lif
);
    localparam int TOTAL_LINES = VSYNC_LINES + VBP_LINES + VERTICAL_ACTIVE_LINES_LINES + VFP_LINES;
    localparam logic [SCAN_W-1:0] LAST_LINE = SCAN_W'(TOTAL_LINES - 1);
    localparam logic [15:0] LAST_CLK = 16'(CLKS_PER_LINE - 1);

    logic [15:0] clk_cnt_reg;
    logic [15:0] clk_cnt_next;
    logic [SCAN_W-1:0] line_reg;
    logic [SCAN_W-1:0] line_next;

    // ---------------------------------------------------------------
    // line and frame counting
    // ---------------------------------------------------------------
    always_comb begin
        clk_cnt_next = clk_cnt_reg;
        line_next = line_reg;
        if (!lif.sleep) begin
            // frozen in sleep: the value is meaningless there anyway
            if (clk_cnt_reg == LAST_CLK) begin
                clk_cnt_next = 16'h0000;
                // wrap to line 0, the first sync line
                line_next = (line_reg == LAST_LINE) ? SCAN_RESET : line_reg + 10'h001;
            end else begin
                clk_cnt_next = clk_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || lif.clear) begin
            clk_cnt_reg <= 16'h0000;
            line_reg <= SCAN_RESET;
        end else begin
            clk_cnt_reg <= clk_cnt_next;
            line_reg <= line_next;
        end
    end

    assign lif.line = line_reg;

endmodule // slb_line_timer

// ### slb_pkg.sv
package slb_pkg;

    // ---------------------------------------------------------------
    // widths and field positions
    // ---------------------------------------------------------------
    localparam int BUS_W = 18;
    localparam int BYTE_W = 8;
    localparam int SCAN_W = 10;
    localparam int SCAN_HI_LSB = 8;
    localparam int SCAN_HI_W = 2;
    localparam int SYNC_STAGES = 3;

    // ---------------------------------------------------------------
    // command codes and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_GET_SCAN = 8'h45;
    localparam logic [7:0] CMD_WR_BRT = 8'h51;
    localparam logic [7:0] CMD_RD_BRT = 8'h52;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] BRT_RESET = 8'h00;
    localparam logic [7:0] BRT_MIN = 8'h00;
    localparam logic [7:0] BRT_MAX = 8'hFF;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic [9:0] SCAN_RESET = 10'h000;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HOST_WAIT_NS = 3000;
    localparam int HOST_WAIT_CYC = (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // command tracking state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SLB_IDLE = 2'b00,
        SLB_SCAN = 2'b01,
        SLB_BWR = 2'b11,
        SLB_BRD = 2'b10
    } slb_cmd_t;

endpackage
